/* File: inc/mat_pkg.sv */
package mat_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_STACK_POINTER        = 8'h81;
  localparam logic [7:0] IDX_CLOCK_CONTROL        = 8'h8E;
  localparam logic [7:0] IDX_INTERNAL_WAIT_STATES = 8'h9C;
  localparam logic [7:0] IDX_EXTERNAL_WAIT_LOW    = 8'h9D;
  localparam logic [7:0] IDX_EXTERNAL_WAIT_HIGH   = 8'h9E;
  localparam logic [7:0] IDX_LATCH_PULSE_DURATION = 8'h9F;
  localparam int         BYTE_ADDR_SHIFT          = 2;

  // Reset values
  localparam logic [7:0] RST_STACK_POINTER        = 8'h07;
  localparam logic [7:0] RST_CLOCK_CONTROL        = 8'h07;
  localparam logic [7:0] RST_INTERNAL_WAIT_STATES = 8'hFF;
  localparam logic [7:0] RST_EXTERNAL_WAIT_LOW    = 8'hFF;
  localparam logic [7:0] RST_EXTERNAL_WAIT_HIGH   = 8'hFF;
  localparam logic [7:0] RST_LATCH_PULSE_DURATION = 8'hFF;

  // Clock control layout: watchdog select bits kept, bits 5:3 read zero
  localparam logic [7:0] CLOCK_CONTROL_WR_MASK    = 8'hC7;
  localparam int         STROBE_WIDTH_SEL_LSB     = 0;
  localparam int         STROBE_WIDTH_SEL_W       = 3;
  localparam logic [2:0] STROBE_WIDTH_SEL_MIN     = 3'h2;

  // Internal wait state field layout
  localparam int         RAM_WAIT_LSB             = 6;
  localparam int         RAM_WAIT_W               = 2;
  localparam int         STACK_ENGINE_WAIT_LSB    = 3;
  localparam int         STACK_ENGINE_WAIT_W      = 3;
  localparam int         FLASH_WAIT_LSB           = 0;
  localparam int         FLASH_WAIT_W             = 3;

  // Timing counts, in core clocks
  localparam int         TIMER_W                  = 17;
  localparam logic [16:0] STROBE_EXTRA            = 17'h00001;
  localparam logic [16:0] RAM_EXTRA               = 17'h00002;
  localparam logic [16:0] SLOW_EXTRA              = 17'h00003;
  localparam logic [16:0] LATCH_EXTRA             = 17'h00001;

  typedef enum logic [2:0] {
    KIND_XREAD,
    KIND_XWRITE,
    KIND_RAM,
    KIND_STACK_ENGINE,
    KIND_FLASH,
    KIND_EXT
  } mat_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_STROBE,
    ST_INTWAIT,
    ST_LATCH,
    ST_EWAIT
  } mat_state_t;

endpackage

/* File: hw/mat_timer.sv */
`timescale 1ns/100ps
module mat_timer #(
  parameter int W = 17
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rstN,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] loadVal,
  // Status
  output logic              last
);

  if (W < 2) begin : g_chkW
    $error("mat_timer: W too small");
  end

  typedef struct packed {
    logic [W-1:0] cnt;
  } mat_timer_state_t;

  mat_timer_state_t s_q;
  mat_timer_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (load) begin
      s_d.cnt = loadVal;
    end else if (s_q.cnt != '0) begin
      s_d.cnt = s_q.cnt - W'(1);
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Final cycle of a loaded count
  assign last = (s_q.cnt == W'(1));

endmodule // mat_timer

/* File: hw/mat_regs.sv */
`timescale 1ns/100ps
module mat_regs
  import mat_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int DATA_W = 32
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // APB slave
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [DATA_W-1:0] pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Memory access requests from the core
  input  wire logic              reqValid,
  input  wire logic [2:0]        reqKind,
  input  wire logic              stdPinMode,
  output logic                   reqReady,
  output logic                   accBusy,
  output logic                   accDone,
  // External pins
  output logic                   extReadStrobe,
  output logic                   extWriteStrobe,
  output logic                   addrLatch,
  // Stack operations
  input  wire logic              stackPush,
  input  wire logic              stackPop,
  output logic      [7:0]        stackPtr,
  output logic      [7:0]        stackAddr,
  output logic                   stackWrite,
  output logic                   stackRead
);

  // Upper address bits start at bit 10, so at least one must exist
  if (DATA_W != 32) begin : g_chkData
    $error("mat_regs: DATA_W must be 32");
  end
  if (ADDR_W < 11) begin : g_chkAddr
    $error("mat_regs: ADDR_W must be at least 11");
  end

  typedef struct packed {
    logic [7:0]  sp;
    logic [7:0]  clockControl;
    logic [7:0]  intWait;
    logic [7:0]  extWaitLow;
    logic [7:0]  extWaitHigh;
    logic [7:0]  latchDur;
    mat_state_t  state;
    logic        reqReady;
    logic        accBusy;
    logic        accDone;
    logic        rdStrobe;
    logic        wrStrobe;
    logic        latch;
    logic [7:0]  stackAddr;
    logic        stackWrite;
    logic        stackRead;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } mat_state_reg_t;

  localparam mat_state_reg_t RESET_STATE = '{
    sp:           RST_STACK_POINTER,
    clockControl: RST_CLOCK_CONTROL,
    intWait:      RST_INTERNAL_WAIT_STATES,
    extWaitLow:   RST_EXTERNAL_WAIT_LOW,
    extWaitHigh:  RST_EXTERNAL_WAIT_HIGH,
    latchDur:     RST_LATCH_PULSE_DURATION,
    state:        ST_IDLE,
    reqReady:     1'b1,
    accBusy:      1'b0,
    accDone:      1'b0,
    rdStrobe:     1'b0,
    wrStrobe:     1'b0,
    latch:        1'b0,
    stackAddr:    8'h00,
    stackWrite:   1'b0,
    stackRead:    1'b0,
    pready:       1'b0,
    pslverr:      1'b0,
    prdata:       32'h00000000
  };

  // Reset release through two flip-flops
  logic [1:0] rstSync_q;
  logic       rstSyncN;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync_q <= 2'b00;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end

  assign rstSyncN = rstSync_q[1];

  mat_state_reg_t s_q;
  mat_state_reg_t s_d;

  logic               timerLoad;
  logic [TIMER_W-1:0] timerVal;
  logic               timerLast;

  mat_timer #(
    .W       (TIMER_W)
  ) u_timer (
    .clk     (clk),
    .rstN    (rstSyncN),
    .load    (timerLoad),
    .loadVal (timerVal),
    .last    (timerLast)
  );

  // Register index decode; upper address bits must be clear
  logic [7:0] regIdx;
  logic       upperClear;
  logic       regHit;
  logic [7:0] regRdVal;

  assign regIdx     = paddr[BYTE_ADDR_SHIFT +: 8];
  assign upperClear = (paddr[ADDR_W-1:BYTE_ADDR_SHIFT+8] == '0) &&
                      (paddr[BYTE_ADDR_SHIFT-1:0] == '0);

  always_comb begin
    regHit   = upperClear;
    regRdVal = 8'h00;
    unique case (regIdx)
      IDX_STACK_POINTER:        regRdVal = s_q.sp;
      IDX_CLOCK_CONTROL:        regRdVal = s_q.clockControl;
      IDX_INTERNAL_WAIT_STATES: regRdVal = s_q.intWait;
      IDX_EXTERNAL_WAIT_LOW:    regRdVal = s_q.extWaitLow;
      IDX_EXTERNAL_WAIT_HIGH:   regRdVal = s_q.extWaitHigh;
      IDX_LATCH_PULSE_DURATION: regRdVal = s_q.latchDur;
      default:                  regHit   = 1'b0;
    endcase
  end

  // Decoded timing settings
  logic [2:0]         strobeSel;
  logic [TIMER_W-1:0] strobeLen;
  logic [TIMER_W-1:0] ramLen;
  logic [TIMER_W-1:0] stackEngLen;
  logic [TIMER_W-1:0] flashLen;
  logic [TIMER_W-1:0] latchLen;
  logic [TIMER_W-1:0] extWaitLen;

  always_comb begin
    strobeSel = s_q.clockControl[STROBE_WIDTH_SEL_LSB +: STROBE_WIDTH_SEL_W];
    if (strobeSel < STROBE_WIDTH_SEL_MIN) begin
      strobeSel = STROBE_WIDTH_SEL_MIN;
    end
    strobeLen   = TIMER_W'(strobeSel) + STROBE_EXTRA;
    ramLen      = TIMER_W'(s_q.intWait[RAM_WAIT_LSB +: RAM_WAIT_W]) + RAM_EXTRA;
    stackEngLen = TIMER_W'(s_q.intWait[STACK_ENGINE_WAIT_LSB +: STACK_ENGINE_WAIT_W])
                  + SLOW_EXTRA;
    flashLen    = TIMER_W'(s_q.intWait[FLASH_WAIT_LSB +: FLASH_WAIT_W]) + SLOW_EXTRA;
    latchLen    = TIMER_W'(s_q.latchDur) + LATCH_EXTRA;
    extWaitLen  = TIMER_W'({s_q.extWaitHigh, s_q.extWaitLow});
  end

  always_comb begin
    s_d        = s_q;
    timerLoad  = 1'b0;
    timerVal   = '0;
    s_d.accDone    = 1'b0;
    s_d.stackWrite = 1'b0;
    s_d.stackRead  = 1'b0;

    // Access sequencer
    unique case (s_q.state)
      ST_IDLE: begin
        if (reqValid) begin
          s_d.accBusy = 1'b1;
          unique case (mat_kind_t'(reqKind))
            KIND_XREAD, KIND_XWRITE: begin
              s_d.state    = ST_STROBE;
              s_d.rdStrobe = (mat_kind_t'(reqKind) == KIND_XREAD);
              s_d.wrStrobe = (mat_kind_t'(reqKind) == KIND_XWRITE);
              timerLoad    = 1'b1;
              timerVal     = strobeLen;
            end
            KIND_RAM: begin
              s_d.state = ST_INTWAIT;
              timerLoad = 1'b1;
              timerVal  = ramLen;
            end
            KIND_STACK_ENGINE: begin
              s_d.state = ST_INTWAIT;
              timerLoad = 1'b1;
              timerVal  = stackEngLen;
            end
            KIND_FLASH: begin
              s_d.state = ST_INTWAIT;
              timerLoad = 1'b1;
              timerVal  = flashLen;
            end
            KIND_EXT: begin
              if (stdPinMode) begin
                s_d.state = ST_LATCH;
                s_d.latch = 1'b1;
                timerLoad = 1'b1;
                timerVal  = latchLen;
              end else if (extWaitLen != '0) begin
                s_d.state = ST_EWAIT;
                timerLoad = 1'b1;
                timerVal  = extWaitLen;
              end else begin
                s_d.accBusy = 1'b0;
                s_d.accDone = 1'b1;
              end
            end
            default: begin
              s_d.accBusy = 1'b0;
              s_d.accDone = 1'b1;
            end
          endcase
        end
      end
      ST_STROBE, ST_INTWAIT, ST_EWAIT: begin
        if (timerLast) begin
          s_d.state    = ST_IDLE;
          s_d.rdStrobe = 1'b0;
          s_d.wrStrobe = 1'b0;
          s_d.accBusy  = 1'b0;
          s_d.accDone  = 1'b1;
        end
      end
      ST_LATCH: begin
        if (timerLast) begin
          s_d.latch = 1'b0;
          if (extWaitLen != '0) begin
            s_d.state = ST_EWAIT;
            timerLoad = 1'b1;
            timerVal  = extWaitLen;
          end else begin
            s_d.state   = ST_IDLE;
            s_d.accBusy = 1'b0;
            s_d.accDone = 1'b1;
          end
        end
      end
      default: begin
        s_d.state = ST_IDLE;
      end
    endcase
    s_d.reqReady = (s_d.state == ST_IDLE);

    // APB: answer one cycle after setup, write lands at the access edge
    s_d.pready = 1'b0;
    if (psel && !penable) begin
      s_d.pready  = 1'b1;
      s_d.pslverr = !regHit;
      s_d.prdata  = regHit ? {24'h000000, regRdVal} : 32'h00000000;
    end
    if (psel && penable && s_q.pready && pwrite && regHit && pstrb[0]) begin
      unique case (regIdx)
        IDX_STACK_POINTER:        s_d.sp = pwdata[7:0];
        IDX_CLOCK_CONTROL:        s_d.clockControl = pwdata[7:0] & CLOCK_CONTROL_WR_MASK;
        IDX_INTERNAL_WAIT_STATES: s_d.intWait = pwdata[7:0];
        IDX_EXTERNAL_WAIT_LOW:    s_d.extWaitLow = pwdata[7:0];
        IDX_EXTERNAL_WAIT_HIGH:   s_d.extWaitHigh = pwdata[7:0];
        IDX_LATCH_PULSE_DURATION: s_d.latchDur = pwdata[7:0];
        default:                  s_d.sp = s_q.sp;
      endcase
    end

    // Core stack operations win over a same-cycle software write
    if (stackPush) begin
      s_d.sp         = s_q.sp + 8'h01;
      s_d.stackAddr  = s_q.sp + 8'h01;
      s_d.stackWrite = 1'b1;
    end else if (stackPop) begin
      s_d.stackAddr = s_q.sp;
      s_d.stackRead = 1'b1;
      s_d.sp        = s_q.sp - 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      s_q <= RESET_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata         = s_q.prdata;
  assign pready         = s_q.pready;
  assign pslverr        = s_q.pslverr;
  assign reqReady       = s_q.reqReady;
  assign accBusy        = s_q.accBusy;
  assign accDone        = s_q.accDone;
  assign extReadStrobe  = s_q.rdStrobe;
  assign extWriteStrobe = s_q.wrStrobe;
  assign addrLatch      = s_q.latch;
  assign stackPtr       = s_q.sp;
  assign stackAddr      = s_q.stackAddr;
  assign stackWrite     = s_q.stackWrite;
  assign stackRead      = s_q.stackRead;

endmodule // mat_regs

/* File: verif/mat_regs_chk.sv */
`timescale 1ns/100ps
module mat_regs_chk #(
  parameter int ADDR_W = 12,
  parameter int DATA_W = 32
) (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // Access handshake
  input wire logic       reqValid,
  input wire logic [2:0] reqKind,
  input wire logic       stdPinMode,
  input wire logic       reqReady,
  input wire logic       accBusy,
  input wire logic       accDone,
  // External pins
  input wire logic       extReadStrobe,
  input wire logic       extWriteStrobe,
  input wire logic       addrLatch,
  // Stack
  input wire logic       stackPush,
  input wire logic       stackPop,
  input wire logic [7:0] stackPtr,
  input wire logic [7:0] stackAddr,
  input wire logic       stackWrite,
  input wire logic       stackRead
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire take = reqValid && reqReady;
  sequence ramRun;
    accBusy [*2] ##[1:4] accDone;
  endsequence
  sequence slowRun;
    accBusy [*3] ##[1:8] accDone;
  endsequence
  AST_RAM_TIME: assert property (take && reqKind == 3'h2 |=> ramRun)
    else $error("ram access length wrong");
  AST_SLOW_TIME: assert property (take && (reqKind == 3'h3 || reqKind == 3'h4) |=> slowRun)
    else $error("engine or flash access length wrong");
  AST_PUSH: assert property (stackPush |=> stackWrite && stackAddr == stackPtr
    && stackPtr == $past(stackPtr) + 8'h01) else $error("push pointer wrong");
  AST_POP: assert property (stackPop && !stackPush |=> stackRead
    && stackAddr == $past(stackPtr) && stackPtr == $past(stackPtr) - 8'h01)
    else $error("pop pointer wrong");
  AST_RD_CAUSE: assert property ($rose(extReadStrobe) |-> $past(take && reqKind == 3'h0))
    else $error("read strobe without read move");
  AST_WR_CAUSE: assert property ($rose(extWriteStrobe) |-> $past(take && reqKind == 3'h1))
    else $error("write strobe without write move");
  wire anyStrobe = extReadStrobe || extWriteStrobe;
  AST_STROBE_MIN: assert property ($rose(anyStrobe) |-> anyStrobe [*3])
    else $error("strobe too short");
  AST_STROBE_MAX: assert property ($rose(anyStrobe) |-> ##[3:8] !anyStrobe)
    else $error("strobe too long");
  AST_LATCH_CAUSE: assert property ($rose(addrLatch) |->
    $past(take && reqKind == 3'h5 && stdPinMode)) else $error("latch outside pin mode");
endmodule // mat_regs_chk

bind mat_regs mat_regs_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (
  .clk, .rst_n, .reqValid, .reqKind, .stdPinMode, .reqReady, .accBusy, .accDone,
  .extReadStrobe, .extWriteStrobe, .addrLatch, .stackPush, .stackPop, .stackPtr,
  .stackAddr, .stackWrite, .stackRead
);

/* File: verif/mat_ext_dev.sv */
`timescale 1ns/100ps
module mat_ext_dev (
  // Clock
  input  wire logic clk,
  // Strobes from the block
  input  wire logic extReadStrobe,
  input  wire logic extWriteStrobe,
  input  wire logic addrLatch,
  // Last pulse widths seen, in clocks
  output int        strobeW,
  output int        latchW
);
  int sc = 0;
  int lc = 0;
  // Width is recorded once the pulse ends
  always @(posedge clk) begin
    if (extReadStrobe || extWriteStrobe) begin
      sc <= sc + 1;
    end else if (sc != 0) begin
      strobeW <= sc;
      sc <= 0;
    end
    if (addrLatch) begin
      lc <= lc + 1;
    end else if (lc != 0) begin
      latchW <= lc;
      lc <= 0;
    end
  end
endmodule // mat_ext_dev

/* File: verif/tb_memory_access_timing_regs.sv */
`timescale 1ns/100ps
module tb_memory_access_timing_regs import mat_pkg::*;;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        reqValid = 1'b0, stdPinMode = 1'b0, stackPush = 1'b0, stackPop = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [2:0]  reqKind = 3'h0;
  logic        pready, pslverr, reqReady, accBusy, accDone, er;
  logic        extReadStrobe, extWriteStrobe, addrLatch, stackWrite, stackRead;
  logic [7:0]  stackPtr, stackAddr;
  int          strobeW, latchW, n, errCount = 0, nTests = 0, cyc = 0;
  logic [7:0]  idxT [6] = '{IDX_STACK_POINTER, IDX_CLOCK_CONTROL, IDX_INTERNAL_WAIT_STATES,
    IDX_EXTERNAL_WAIT_LOW, IDX_EXTERNAL_WAIT_HIGH, IDX_LATCH_PULSE_DURATION};
  logic [7:0]  rstT [6] = '{RST_STACK_POINTER, RST_CLOCK_CONTROL, RST_INTERNAL_WAIT_STATES,
    RST_EXTERNAL_WAIT_LOW, RST_EXTERNAL_WAIT_HIGH, RST_LATCH_PULSE_DURATION};

  mat_regs u_dut (.clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb(4'hF),
    .prdata, .pready, .pslverr, .reqValid, .reqKind, .stdPinMode, .reqReady, .accBusy,
    .accDone, .extReadStrobe, .extWriteStrobe, .addrLatch, .stackPush, .stackPop,
    .stackPtr, .stackAddr, .stackWrite, .stackRead);
  mat_ext_dev u_dev (.clk, .extReadStrobe, .extWriteStrobe, .addrLatch, .strobeW, .latchW);

  initial forever #2 clk = ~clk;

  task automatic completeRun;
    $display("Compares %0d, mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errCount++;
      completeRun;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      errCount++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdChk(input logic [7:0] idx, input logic [7:0] exp, input logic e);
    apb(1'b0, idx, 8'h00);
    chk(rd, {24'h0, exp});
    chk({31'h0, er}, {31'h0, e});
  endtask

  // Busy cycles of one access, counted up to its done pulse
  task automatic acc(input logic [2:0] k, output int c);
    reqValid <= 1'b1;
    reqKind <= k;
    do @(posedge clk); while (reqReady !== 1'b1);
    reqValid <= 1'b0;
    c = 0;
    do begin
      @(posedge clk);
      c += (accBusy === 1'b1);
    end while (accDone !== 1'b1);
  endtask

  task automatic stk(input logic p, input logic q, input logic [31:0] exp);
    stackPush <= p;
    stackPop <= q;
    @(posedge clk);
    stackPush <= 1'b0;
    stackPop <= 1'b0;
    @(posedge clk);
    chk(32'({stackWrite, stackRead, stackPtr, stackAddr}), exp);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 6; i++) rdChk(idxT[i], rstT[i], 1'b0);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, idxT[i], 8'hA5);
      rdChk(idxT[i], (i == 1) ? 8'h85 : 8'hA5, 1'b0);
    end
    rdChk(8'h80, 8'h00, 1'b1);
    $display("Test registers done");
    for (int s = 0; s < 8; s++) begin
      apb(1'b1, IDX_CLOCK_CONTROL, 8'(s));
      acc(3'(s % 2), n);
      @(posedge clk);
      chk(32'(n), (s < 2) ? 32'h3 : 32'(s + 1));
      chk(32'(strobeW), (s < 2) ? 32'h3 : 32'(s + 1));
    end
    $display("Test strobe done");
    for (int w = 0; w < 8; w++) begin
      apb(1'b1, IDX_INTERNAL_WAIT_STATES, {w[1:0], w[2:0], w[2:0]});
      acc(3'h2, n);
      chk(32'(n), 32'(w % 4 + 2));
      acc(3'h3, n);
      chk(32'(n), 32'(w + 3));
      acc(3'h4, n);
      chk(32'(n), 32'(w + 3));
    end
    acc(3'h6, n);
    chk(32'(n), 32'h0);
    $display("Test internal waits done");
    stdPinMode <= 1'b1;
    apb(1'b1, IDX_LATCH_PULSE_DURATION, 8'h01);
    apb(1'b1, IDX_EXTERNAL_WAIT_LOW, 8'h02);
    apb(1'b1, IDX_EXTERNAL_WAIT_HIGH, 8'h00);
    acc(3'h5, n);
    @(posedge clk);
    chk(32'(n), 32'h4);
    chk(32'(latchW), 32'h2);
    apb(1'b1, IDX_EXTERNAL_WAIT_HIGH, 8'h01);
    acc(3'h5, n);
    chk(32'(n), 32'h104);
    stdPinMode <= 1'b0;
    acc(3'h5, n);
    chk(32'(n), 32'h102);
    $display("Test external done");
    apb(1'b1, IDX_STACK_POINTER, 8'hFE);
    stk(1'b1, 1'b0, 32'h2FFFF);
    stk(1'b0, 1'b1, 32'h1FEFF);
    stk(1'b1, 1'b1, 32'h2FFFF);
    stk(1'b1, 1'b0, 32'h20000);
    rdChk(IDX_STACK_POINTER, 8'h00, 1'b0);
    $display("Test stack done");
    completeRun;
  end
endmodule // tb_memory_access_timing_regs
